/* File: rtl/lplt_features.sv */
`timescale 1ns/1ns
`default_nettype none
module lplt_features (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 frame_strobe,
    input  wire lplt_pkg::lplt_in_type frame_in,
    output var  lplt_pkg::lplt_feat_type feat,
    output logic                      feat_valid
);
    import lplt_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Fixed point: all features except noise_close_count signed, FRAC fraction bits
    if (W < FRAC + 8 || FRAC < 8) begin : g_check
        $error("Feature width too small for gain range");
    end

    lplt_feat_type feat_reg;
    lplt_feat_type feat_next;
    logic          valid_reg;
    logic          valid_next;

    // Recursive average: prev + alpha * (x - prev)
    function automatic logic [W-1:0] ema(input logic [W-1:0] prev, input logic [W-1:0] x,
                                         input logic [15:0] alpha);
        logic signed [W:0]    diff;
        logic signed [W+17:0] prod;
        diff = $signed({x[W-1], x}) - $signed({prev[W-1], prev});
        prod = diff * $signed({1'b0, alpha});
        ema  = prev + W'(prod >>> CF);
    endfunction

    // Clipped quotient num/den in FRAC format
    function automatic logic [W-1:0] clip_gain(input logic [RW-1:0] num, input logic [RW-1:0] den);
        logic [RW+FRAC-1:0] q;
        q = '0;
        if (den != 0) begin
            q = {num, FRAC'(0)} / {FRAC'(0), den};
        end
        if (den == 0 || q >= (RW+FRAC)'(GAIN_MAX)) begin
            clip_gain = GAIN_MAX;
        end else begin
            clip_gain = W'(q);
        end
    endfunction

    function automatic logic [W-1:0] smax(input logic [W-1:0] a, input logic [W-1:0] b);
        smax = ($signed(a) > $signed(b)) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Per-frame feature update
    always_comb begin
        logic [W-1:0] lg;
        logic [W-1:0] hg;
        logic [W-1:0] ndist;
        logic [W-1:0] mdist;
        logic [W-1:0] near_ind;
        lg         = clip_gain(frame_in.energy_order0, frame_in.energy_order2);
        hg         = clip_gain(frame_in.energy_order2, frame_in.energy_order16);
        ndist      = frame_in.frame_energy - frame_in.noise_level;
        mdist      = frame_in.frame_energy - frame_in.long_term_min_energy;
        near_ind   = ($signed(ndist) < $signed(NEAR_THR)) ? ONE : FEAT_RESET;
        feat_next  = feat_reg;
        valid_next = frame_strobe;
        if (frame_strobe) begin
            feat_next.low_order_pred_gain = lg;
            feat_next.low_gain_avg = ema(feat_reg.low_gain_avg, lg, A_015);
            feat_next.low_dev = ($signed(feat_next.low_gain_avg) > $signed(lg))
                              ? feat_next.low_gain_avg - lg : lg - feat_next.low_gain_avg;
            feat_next.low_dev_avg = ema(feat_reg.low_dev_avg, feat_next.low_dev,
                ($signed(feat_next.low_dev) < $signed(feat_reg.low_dev_avg)) ? A_010 : A_020);
            feat_next.low_peak_dev = smax(feat_next.low_dev_avg, feat_next.low_dev);
            feat_next.high_order_pred_gain = hg;
            feat_next.fast_high_order_gain_avg = ema(feat_reg.fast_high_order_gain_avg, hg,
                ($signed(hg) > $signed(feat_reg.fast_high_order_gain_avg)) ? A_020 : A_003);
            feat_next.slow_high_order_gain_avg = ema(feat_reg.slow_high_order_gain_avg, hg, A_002);
            feat_next.high_dev = feat_next.fast_high_order_gain_avg
                               - feat_next.slow_high_order_gain_avg;
            feat_next.high_dev_avg = ema(feat_reg.high_dev_avg, feat_next.high_dev,
                ($signed(feat_next.high_dev) < $signed(feat_reg.high_dev_avg)) ? A_002 : A_005);
            feat_next.high_peak_dev = smax(feat_next.high_dev_avg, feat_next.high_dev);
            feat_next.noise_distance_avg = ema(feat_reg.noise_distance_avg, ndist, A_003);
            feat_next.noise_track_avg = ema(feat_reg.noise_track_avg, near_ind, A_003);
            if ($signed(feat_reg.noise_track_avg) >= $signed(TRACK_THR)) begin
                feat_next.noise_close_count = '0;
            end else if (feat_reg.noise_close_count != '1) begin
                feat_next.noise_close_count = feat_reg.noise_close_count + CW'(1);
            end
            feat_next.min_energy_distance_avg = ema(feat_reg.min_energy_distance_avg, mdist, A_003);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            feat_reg  <= '0;
            valid_reg <= 1'b0;
        end else begin
            feat_reg  <= feat_next;
            valid_reg <= valid_next;
        end
    end

    assign feat       = feat_reg;
    assign feat_valid = valid_reg;

    ////////////////////////////////////////////////////////////////
    // Checks
    property p_low_gain_range;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> (feat.low_order_pred_gain <= GAIN_MAX);
    endproperty
    a_low_gain_range: assert property (p_low_gain_range) else $error("low gain out of range");

    property p_high_gain_range;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && frame_in.energy_order16 == 0 |=> feat.high_order_pred_gain == GAIN_MAX;
    endproperty
    a_high_gain_range: assert property (p_high_gain_range) else $error("high gain not clipped");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !frame_strobe |=> $stable(feat) && !feat_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("state moved without strobe");

    property p_valid;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe |=> feat_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("no valid after strobe");

    property p_low_peak;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> $signed(feat.low_peak_dev) >= $signed(feat.low_dev)
                    && $signed(feat.low_peak_dev) >= $signed(feat.low_dev_avg);
    endproperty
    a_low_peak: assert property (p_low_peak) else $error("low peak not maximum");

    property p_high_peak;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> $signed(feat.high_peak_dev) >= $signed(feat.high_dev)
                    && $signed(feat.high_peak_dev) >= $signed(feat.high_dev_avg);
    endproperty
    a_high_peak: assert property (p_high_peak) else $error("high peak not maximum");

    property p_high_dev;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> feat.high_dev == feat.fast_high_order_gain_avg - feat.slow_high_order_gain_avg;
    endproperty
    a_high_dev: assert property (p_high_dev) else $error("high deviation mismatch");

    property p_count_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && $signed(feat.noise_track_avg) >= $signed(TRACK_THR) |=> feat.noise_close_count == 0;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

    property p_count_inc;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && $signed(feat.noise_track_avg) < $signed(TRACK_THR) && feat.noise_close_count != '1
        |=> feat.noise_close_count == $past(feat.noise_close_count) + CW'(1);
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("counter not incremented");

    property p_track_range;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> !feat.noise_track_avg[W-1] && feat.noise_track_avg <= ONE;
    endproperty
    a_track_range: assert property (p_track_range) else $error("tracking average out of range");

    property p_low_dev_abs;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> !feat.low_dev[W-1];
    endproperty
    a_low_dev_abs: assert property (p_low_dev_abs) else $error("low deviation negative");

    property p_low_gain_clip;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && {3'b000, frame_in.energy_order0} >= {frame_in.energy_order2, 3'b000}
        |=> feat.low_order_pred_gain == GAIN_MAX;
    endproperty
    a_low_gain_clip: assert property (p_low_gain_clip) else $error("low gain not clipped");

    property p_low_avg_range;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> !feat.low_gain_avg[W-1] && feat.low_gain_avg <= GAIN_MAX;
    endproperty
    a_low_avg_range: assert property (p_low_avg_range) else $error("low gain average out of range");

    property p_low_dev_avg_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe |=> (($signed(feat.low_dev) < $signed($past(feat.low_dev_avg)))
                        ? $signed(feat.low_dev_avg) <= $signed($past(feat.low_dev_avg))
                        : $signed(feat.low_dev_avg) >= $signed($past(feat.low_dev_avg)));
    endproperty
    a_low_dev_avg_dir: assert property (p_low_dev_avg_dir) else $error("low deviation average wrong way");

    property p_fast_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe |=> (($signed(feat.high_order_pred_gain) > $signed($past(feat.fast_high_order_gain_avg)))
                        ? $signed(feat.fast_high_order_gain_avg) >= $signed($past(feat.fast_high_order_gain_avg))
                        : $signed(feat.fast_high_order_gain_avg) <= $signed($past(feat.fast_high_order_gain_avg)));
    endproperty
    a_fast_dir: assert property (p_fast_dir) else $error("fast high average wrong way");

    property p_slow_range;
        @(posedge sys_clk) disable iff (!rst_n)
        feat_valid |-> !feat.slow_high_order_gain_avg[W-1] && feat.slow_high_order_gain_avg <= GAIN_MAX;
    endproperty
    a_slow_range: assert property (p_slow_range) else $error("slow high average out of range");

    property p_high_dev_avg_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe |=> (($signed(feat.high_dev) < $signed($past(feat.high_dev_avg)))
                        ? $signed(feat.high_dev_avg) <= $signed($past(feat.high_dev_avg))
                        : $signed(feat.high_dev_avg) >= $signed($past(feat.high_dev_avg)));
    endproperty
    a_high_dev_avg_dir: assert property (p_high_dev_avg_dir) else $error("high deviation average wrong way");

    property p_noise_dist_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && $signed(frame_in.frame_energy - frame_in.noise_level) >= $signed(feat.noise_distance_avg)
        |=> $signed(feat.noise_distance_avg) >= $signed($past(feat.noise_distance_avg));
    endproperty
    a_noise_dist_rise: assert property (p_noise_dist_rise) else $error("noise distance average fell");

    property p_track_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && $signed(frame_in.frame_energy - frame_in.noise_level) < $signed(NEAR_THR)
        |=> $signed(feat.noise_track_avg) >= $signed($past(feat.noise_track_avg));
    endproperty
    a_track_rise: assert property (p_track_rise) else $error("tracking average fell on near frame");

    property p_min_dist_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        frame_strobe && $signed(frame_in.frame_energy - frame_in.long_term_min_energy)
                        >= $signed(feat.min_energy_distance_avg)
        |=> $signed(feat.min_energy_distance_avg) >= $signed($past(feat.min_energy_distance_avg));
    endproperty
    a_min_dist_rise: assert property (p_min_dist_rise) else $error("minimum distance average fell");
endmodule // lplt_features
`default_nettype wire

/* File: shared/lplt_pkg.sv */
// Notes on behaviour
// - Low gain: input over order-2 energy, clip 0..8
// - Low gain average: 0.85 old plus 0.15 new
// - Low deviation: abs(average minus current low gain)
// - Average low deviation; 0.1 if falling, else 0.2
// - Low peak: max of averaged and current deviation
// - High gain: order-2 over order-16 energy, clip 0..8
// - Fast high average: 0.20 rising, else 0.03
// - Slow high average: constant weight 0.02
// - High deviation: fast minus slow, signed
// - Average high deviation; 0.02 falling, else 0.05
// - High peak: max of averaged and current deviation
// - Average energy above noise level, weight 0.03
// - Average of (energy minus noise below 10), weight 0.03
// - Counter clears if tracking average >= 0.05, else increments, holding at all ones
// - Average energy above long-term minimum, weight 0.03
`default_nettype none
package lplt_pkg;
    localparam int FRAC    = 12;
    localparam int W       = 24;
    localparam int RW      = 32;
    localparam int CW      = 16;
    localparam int CF      = 15;
    localparam logic [W-1:0] GAIN_MAX  = 24'h008000;
    localparam logic [W-1:0] ONE       = 24'h001000;
    localparam logic [W-1:0] NEAR_THR  = 24'h00A000;
    localparam logic [W-1:0] TRACK_THR = 24'h0000CD;
    localparam logic [15:0]  A_015 = 16'h1333;
    localparam logic [15:0]  A_010 = 16'h0CCD;
    localparam logic [15:0]  A_020 = 16'h199A;
    localparam logic [15:0]  A_003 = 16'h03D7;
    localparam logic [15:0]  A_002 = 16'h028F;
    localparam logic [15:0]  A_005 = 16'h0666;
    localparam logic [W-1:0] FEAT_RESET = 24'h000000;

    typedef struct packed {
        logic [RW-1:0] energy_order0;
        logic [RW-1:0] energy_order2;
        logic [RW-1:0] energy_order16;
        logic [W-1:0]  frame_energy;
        logic [W-1:0]  noise_level;
        logic [W-1:0]  long_term_min_energy;
    } lplt_in_type;

    typedef struct packed {
        logic [W-1:0]  low_order_pred_gain;
        logic [W-1:0]  low_gain_avg;
        logic [W-1:0]  low_dev;
        logic [W-1:0]  low_dev_avg;
        logic [W-1:0]  low_peak_dev;
        logic [W-1:0]  high_order_pred_gain;
        logic [W-1:0]  fast_high_order_gain_avg;
        logic [W-1:0]  slow_high_order_gain_avg;
        logic [W-1:0]  high_dev;
        logic [W-1:0]  high_dev_avg;
        logic [W-1:0]  high_peak_dev;
        logic [W-1:0]  noise_distance_avg;
        logic [W-1:0]  noise_track_avg;
        logic [CW-1:0] noise_close_count;
        logic [W-1:0]  min_energy_distance_avg;
    } lplt_feat_type;
endpackage
`default_nettype wire

/* File: bench/lplt_upstream_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lplt_upstream_model (
    input  wire logic                  sys_clk,
    output logic                       frame_strobe,
    output var lplt_pkg::lplt_in_type  frame_in
);
    import lplt_pkg::*;
    initial begin
        frame_strobe = 1'b0;
        frame_in     = '0;
    end
    // One frame, held through its strobe edge; if last, then scrambled with strobe dropped
    task automatic send(input lplt_in_type x, input bit last);
        frame_in     <= x;
        frame_strobe <= 1'b1;
        @(posedge sys_clk);
        if (last) begin
            frame_strobe <= 1'b0;
            frame_in     <= ~x;
        end
    endtask
endmodule // lplt_upstream_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import lplt_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst_n   = 1'b0;
    logic          frame_strobe;
    lplt_in_type   frame_in;
    lplt_feat_type feat;
    logic          feat_valid;
    lplt_feat_type q[$];
    lplt_feat_type m = '0;
    lplt_feat_type e;
    int            error_cnt = 0;
    int            n_checks  = 0;
    always #20 sys_clk = ~sys_clk;
    lplt_upstream_model up (.sys_clk(sys_clk), .frame_strobe(frame_strobe), .frame_in(frame_in));
    lplt_features dut (.sys_clk(sys_clk), .rst_n(rst_n), .frame_strobe(frame_strobe), .frame_in(frame_in),
                       .feat(feat), .feat_valid(feat_valid));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [351:0] ex, input logic [351:0] got);
        n_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, ex, got);
        end
    endtask
    task automatic chk1(input string n, input logic ex, input logic got);
        chk(n, {351'h0, ex}, {351'h0, got});
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic bit lt(input logic [W-1:0] a, input logic [W-1:0] b);
        return $signed(a) < $signed(b);
    endfunction
    function automatic logic [W-1:0] avg(input logic [W-1:0] p, input logic [W-1:0] x, input logic [15:0] a);
        longint d;
        d = longint'($signed(x)) - longint'($signed(p));
        return p + W'((d * longint'(a)) >>> 15);
    endfunction
    function automatic logic [W-1:0] gain(input logic [RW-1:0] n, input logic [RW-1:0] d);
        longint g;
        if (d == 0) return GAIN_MAX;
        g = (longint'(n) * 4096) / longint'(d);
        return (g >= 32768) ? GAIN_MAX : W'(g);
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic frame(input lplt_in_type x, input bit last);
        logic [W-1:0]  d;
        lplt_feat_type p;
        p = m;
        m.low_order_pred_gain = gain(x.energy_order0, x.energy_order2);
        m.low_gain_avg = avg(p.low_gain_avg, m.low_order_pred_gain, A_015);
        d = m.low_gain_avg - m.low_order_pred_gain;
        m.low_dev = lt(d, '0) ? -d : d;
        m.low_dev_avg = avg(p.low_dev_avg, m.low_dev, lt(m.low_dev, p.low_dev_avg) ? A_010 : A_020);
        m.low_peak_dev = lt(m.low_dev, m.low_dev_avg) ? m.low_dev_avg : m.low_dev;
        m.high_order_pred_gain = gain(x.energy_order2, x.energy_order16);
        d = m.high_order_pred_gain;
        m.fast_high_order_gain_avg = avg(p.fast_high_order_gain_avg, d,
                                         lt(p.fast_high_order_gain_avg, d) ? A_020 : A_003);
        m.slow_high_order_gain_avg = avg(p.slow_high_order_gain_avg, d, A_002);
        m.high_dev = m.fast_high_order_gain_avg - m.slow_high_order_gain_avg;
        m.high_dev_avg = avg(p.high_dev_avg, m.high_dev, lt(m.high_dev, p.high_dev_avg) ? A_002 : A_005);
        m.high_peak_dev = lt(m.high_dev, m.high_dev_avg) ? m.high_dev_avg : m.high_dev;
        d = x.frame_energy - x.noise_level;
        m.noise_distance_avg = avg(p.noise_distance_avg, d, A_003);
        m.noise_track_avg = avg(p.noise_track_avg, lt(d, NEAR_THR) ? ONE : '0, A_003);
        m.noise_close_count = lt(p.noise_track_avg, TRACK_THR) ? p.noise_close_count + 16'h0001 : '0;
        m.min_energy_distance_avg = avg(p.min_energy_distance_avg, x.frame_energy - x.long_term_min_energy, A_003);
        q.push_back(m);
        up.send(x, last);
    endtask
    task automatic run_frames(input int n, input bit burst, input int b);
        lplt_in_type x;
        @(posedge sys_clk);
        for (int i = b; i < b + n; i++) begin
            x.energy_order0 = (i % 3 == 0) ? 32'h00001388 : 32'(100 * (i + 1));
            x.energy_order2 = 32'(100 + 20 * i);
            x.energy_order16 = (i % 5 == 4) ? 32'h00000000 : 32'(50 * (i % 4 + 1));
            x.frame_energy = (i % 4 == 0) ? 24'h01B000 : ((i % 7 == 5) ? 24'h01A000 : 24'h014000);
            x.noise_level = 24'h010000;
            x.long_term_min_energy = 24'h018000;
            frame(x, !burst || i == b + n - 1);
            if (!burst) @(posedge sys_clk);
        end
    endtask
    task automatic drain();
        repeat (20) if (q.size() != 0) @(posedge sys_clk);
        #1 chk1("drained", 1'b1, q.size() == 0);
    endtask
    always @(posedge sys_clk) begin
        if (feat_valid === 1'b1 && q.size() == 0) chk1("feat_valid", 1'b0, feat_valid);
        else if (feat_valid === 1'b1) begin
            e = q.pop_front();
            chk("low", e[351:232], feat[351:232]);
            chk("high", e[231:88], feat[231:88]);
            chk("noise", e[87:0], feat[87:0]);
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (4) @(posedge sys_clk);
        chk("reset", '0, feat);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 chk1("valid", 1'b0, feat_valid);
    endtask
    task automatic t_spaced();
        run_frames(12, 1'b0, 0);
        drain();
    endtask
    task automatic t_burst();
        run_frames(6, 1'b1, 12);
        drain();
    endtask
    task automatic t_idle();
        repeat (6) @(posedge sys_clk);
        #1 chk("idle", m, feat);
    endtask
    task automatic t_midreset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        #1 chk("mid reset", '0, feat);
        m = '0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        run_frames(4, 1'b0, 3);
        drain();
    endtask
    initial begin
        #(40 * 2000);
        error_cnt++;
        end_sim();
    end
    initial begin
        t_reset();
        t_spaced();
        t_burst();
        t_idle();
        t_midreset();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
